/* rtl/batch_counter_controller.sv */
// Batch counter controller with AHB-Lite register slave
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module batch_counter_controller
  import batch_pkg::*;
#(
  parameter int SLOW_CYC  = SLOW_CYC_DEF,
  parameter int MED_CYC   = MED_CYC_DEF,
  parameter int RSTIN_CYC = RSTIN_CYC_DEF,
  parameter int SEC_CYC   = SEC_CYC_DEF,
  parameter int OUT_HALF  = OUT_HALF_DEF
)
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Field inputs and switches
  input  wire logic        pulse_in,
  input  wire logic        reset_in,
  input  wire logic        filter_select_bit_a,
  input  wire logic        filter_select_bit_b,
  input  wire logic        input_polarity_bit_a,
  input  wire logic        input_polarity_bit_b,
  // Keypad
  input  wire key_t        keys,
  // Outputs
  output logic             prewarn_relay,
  output logic             preset_relay,
  output logic             started,
  output logic             locked,
  output logic             pulse_out,
  output logic             data_lost,
  output logic [15:0]      analog_ua
);

  state_t      q;
  state_t      d;
  logic        raw;
  logic [19:0] thr;
  logic        pv;
  logic        fac;
  logic        racc;
  logic        dec;
  logic        pw;
  logic        ps;
  logic        dig;
  logic [15:0] hist_n;
  logic        lock_hit;
  logic        start_ok;
  logic        rin_acc;
  logic        bclr;
  logic [31:0] acc_n;
  logic [8:0]  el;
  logic [21:0] half;
  logic [31:0] r;
  logic [63:0] num;
  logic        av;

  function automatic logic [15:0] nz1(input logic [15:0] k);
    nz1 = (k == 16'h0000) ? 16'h0001 : k;
  endfunction : nz1

  function automatic logic signed [31:0] sg(input logic [31:0] v);
    sg = $signed(v);
  endfunction : sg

  // Threshold compare on the registered count
  always_comb
  begin
    if (q.mode_dn)
    begin
      pw = sg(q.count) <= sg(q.prewarn);
      ps = sg(q.count) <= 32'sh0;
    end
    else
    begin
      pw = sg(q.count) >= sg(q.preset) - sg(q.prewarn);
      ps = sg(q.count) >= sg(q.preset);
    end
  end

  assign dig      = keys.valid && keys.code <= KEY_DMAX && q.run == ST_STOP;
  assign hist_n   = {q.hist[11:0], keys.code};
  assign lock_hit = dig && hist_n == q.code;
  assign start_ok = keys.valid && keys.code == KEY_START && q.run == ST_STOP
                    && !(pw && ps);
  assign rin_acc  = reset_in && q.rcnt == 18'(RSTIN_CYC - 1);
  assign bclr     = rin_acc || (keys.valid && keys.code == KEY_CLEAR
                    && q.run == ST_STOP && !q.locked && !q.gview);
  assign pv       = q.flt && !q.flt_d;
  assign av       = hsel && hready && htrans[1];

  always_comb
  begin
    d = q;
    fac = 1'b0;
    racc = 1'b0;
    dec = 1'b0;
    el = 9'h0;
    acc_n = 32'h0;
    half = 22'(OUT_HALF);
    r = q.rate;
    num = 64'h0;
    // Input conditioning and width qualification
    raw = pulse_in ^ (input_polarity_bit_b && !input_polarity_bit_a);
    if (filter_select_bit_a && filter_select_bit_b)
      thr = 20'(SLOW_CYC);
    else if (filter_select_bit_a)
      thr = 20'(MED_CYC);
    else
      thr = 20'(FAST_CYC);
    d.flt_d = q.flt;
    if (raw == q.flt)
      d.fcnt = 20'h0;
    else if (q.fcnt >= thr - 20'h1)
    begin
      d.flt = raw;
      d.fcnt = 20'h0;
    end
    else
      d.fcnt = q.fcnt + 20'h1;
    // Reset input needs a long steady high
    if (!reset_in)
      d.rcnt = 18'h0;
    else if (q.rcnt != 18'(RSTIN_CYC))
      d.rcnt = q.rcnt + 18'h1;
    // Count and rate dividers
    if (pv)
    begin
      if (q.cpre >= nz1(q.kc) - 16'h1)
      begin
        d.cpre = 16'h0;
        fac = 1'b1;
      end
      else
        d.cpre = q.cpre + 16'h1;
      if (q.rpre >= nz1(q.kr) - 16'h1)
      begin
        d.rpre = 16'h0;
        racc = 1'b1;
      end
      else
        d.rpre = q.rpre + 16'h1;
    end
    // Rate over one second, else over the averaging window
    acc_n = q.acc + {31'h0, racc};
    d.acc = acc_n;
    if (q.sec == 26'(SEC_CYC - 1))
    begin
      d.sec = 26'h0;
      el = {1'b0, q.secs} + 9'h1;
      if (acc_n != 32'h0 || el >= nz1({8'h0, q.win}))
      begin
        d.rate = acc_n / {23'h0, el};
        d.acc = 32'h0;
        d.secs = 8'h0;
      end
      else
        d.secs = el[7:0];
    end
    else
      d.sec = q.sec + 26'h1;
    // Totals, counted whether started or not
    if (fac)
    begin
      d.count = q.mode_dn ? q.count - 32'h1 : q.count + 32'h1;
      d.grand = q.grand + 32'h1;
    end
    if (bclr)
      d.count = q.mode_dn ? q.preset : 32'h0;
    // Keypad
    if (keys.valid)
    begin
      if (dig)
        d.hist = hist_n;
      if (lock_hit)
      begin
        d.locked = !q.locked;
        d.hist = HIST_RST;
      end
      if (keys.code == KEY_ENTER)
        d.gview = !q.gview;
      if (keys.code == KEY_CLEAR && q.run == ST_STOP && !q.locked && q.gview)
        d.grand = 32'h0;
      if (start_ok)
        d.run = ST_RUN;
      if (keys.code == KEY_STOP)
        d.run = ST_STOP;
    end
    if (q.run == ST_RUN && ps)
      d.run = ST_STOP;
    // Frequency output with pending pulse store
    unique case (q.spd)
      2'b00: half = 22'(OUT_HALF * 2000);
      2'b01: half = 22'(OUT_HALF * 100);
      2'b10: half = 22'(OUT_HALF * 10);
      2'b11: half = 22'(OUT_HALF);
    endcase
    if (q.pcnt < half - 22'h1)
      d.pcnt = q.pcnt + 22'h1;
    else if (q.pout)
    begin
      d.pout = 1'b0;
      d.pcnt = 22'h0;
    end
    else if (q.pend != 14'h0)
    begin
      d.pout = 1'b1;
      d.pcnt = 22'h0;
      dec = 1'b1;
    end
    // An overflow in the same cycle as a batch clear keeps the flag set
    if (bclr)
      d.lost = 1'b0;
    if (fac && q.pend == PEND_MAX && !dec)
      d.lost = 1'b1;
    else
      d.pend = q.pend + {13'h0, fac} - {13'h0, dec};
    // Analog level in microamps
    if (sg(r) < sg(q.lo))
      r = q.lo;
    if (sg(r) > sg(q.hi))
      r = q.hi;
    if (sg(q.hi) > sg(q.lo))
    begin
      num = AN_SPAN * {32'h0, r - q.lo};
      d.analog = AN_BASE + 16'(num / {32'h0, q.hi - q.lo});
    end
    else
      d.analog = AN_BASE;
    // Register writes in the data phase
    if (q.a_wr)
    begin
      unique case (q.a_addr)
        OFF_PRESET: d.preset = hwdata;
        OFF_CTRL:
          if (!q.locked)
          begin
            d.mode_dn = hwdata[0];
            d.spd = hwdata[2:1];
          end
        OFF_PREWARN: if (!q.locked) d.prewarn = hwdata;
        OFF_KCOUNT:  if (!q.locked) d.kc = hwdata[15:0];
        OFF_KRATE:   if (!q.locked) d.kr = hwdata[15:0];
        OFF_WINDOW:  if (!q.locked) d.win = hwdata[7:0];
        OFF_SET_LOW: if (!q.locked) d.lo = hwdata;
        OFF_SET_HI:  if (!q.locked) d.hi = hwdata;
        OFF_CODE:    if (!q.locked) d.code = hwdata[15:0];
        default: ;
      endcase
    end
    // Address phase: latch write intent, fetch read data
    d.a_wr = av && hwrite;
    d.a_addr = haddr[7:0];
    if (av && !hwrite)
    begin
      unique case (haddr[7:0])
        OFF_CTRL:    d.rdata = {29'h0, q.spd, q.mode_dn};
        OFF_PRESET:  d.rdata = q.preset;
        OFF_PREWARN: d.rdata = q.prewarn;
        OFF_KCOUNT:  d.rdata = {16'h0, q.kc};
        OFF_KRATE:   d.rdata = {16'h0, q.kr};
        OFF_WINDOW:  d.rdata = {24'h0, q.win};
        OFF_SET_LOW: d.rdata = q.lo;
        OFF_SET_HI:  d.rdata = q.hi;
        OFF_CODE:    d.rdata = q.locked ? 32'h0 : {16'h0, q.code};
        OFF_STATUS:  d.rdata = {26'h0, q.lost, q.gview, ps, pw, q.run, q.locked};
        OFF_COUNT:   d.rdata = q.count;
        OFF_GRAND:   d.rdata = q.grand;
        OFF_RATE:    d.rdata = q.rate;
        OFF_ANALOG:  d.rdata = {16'h0, q.analog};
        default:     d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.kc <= 16'h1;
      q.kr <= 16'h1;
      q.win <= 8'h1;
      q.code <= CODE_RST;
      q.hist <= HIST_RST;
      q.run <= ST_STOP;
    end
    else
      q <= d;
  end

  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = q.rdata;
  assign started       = q.run == ST_RUN;
  assign prewarn_relay = started && !pw;
  assign preset_relay  = started && !ps;
  assign locked        = q.locked;
  assign pulse_out     = q.pout;
  assign data_lost     = q.lost;
  assign analog_ua     = q.analog;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_lock;
    lock_hit |=> locked != $past(locked);
  endproperty
  a_lock: assert property (p_lock) else $error("lock did not toggle");

  property p_code_ro;
    q.locked && q.a_wr && q.a_addr == OFF_CODE |=> $stable(q.code);
  endproperty
  a_code_ro: assert property (p_code_ro) else $error("code changed while locked");

  property p_refuse;
    keys.valid && keys.code == KEY_START && !started && pw && ps |=> !started;
  endproperty
  a_refuse: assert property (p_refuse) else $error("start not refused");

  property p_run_keys;
    started && keys.valid && keys.code <= KEY_DMAX |=> $stable(locked);
  endproperty
  a_run_keys: assert property (p_run_keys) else $error("digit acted while started");

  property p_stop;
    keys.valid && keys.code == KEY_STOP |=> !started && !prewarn_relay && !preset_relay;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not release relays");

  property p_resume;
    start_ok && !fac && !bclr |=> started && q.count == $past(q.count);
  endproperty
  a_resume: assert property (p_resume) else $error("start altered count");

  property p_rin;
    rin_acc |=> q.count == (q.mode_dn ? q.preset : 32'h0);
  endproperty
  a_rin: assert property (p_rin) else $error("reset input did not clear");

  property p_rin_len;
    $rose(reset_in) |-> !rin_acc [*8];
  endproperty
  a_rin_len: assert property (p_rin_len) else $error("short reset accepted");

  property p_pend;
    q.pend <= PEND_MAX;
  endproperty
  a_pend: assert property (p_pend) else $error("pending store overrun");

  property p_prewarn_rly;
    started && pw |-> !prewarn_relay;
  endproperty
  a_prewarn_rly: assert property (p_prewarn_rly) else $error("prewarn relay held");

  c_start: cover property (start_ok ##1 started);
  c_lock: cover property (lock_hit ##1 locked);
  c_pulse: cover property ($rose(pulse_out));
  c_halt: cover property (started ##1 !started && ps);

endmodule : batch_counter_controller
`default_nettype wire

/* rtl/batch_pkg.sv */
// Constants, types and register map of the batch counter controller
package batch_pkg;

  localparam int CLK_NS    = 25;
  localparam int SLOW_US   = 12500;
  localparam int MED_US    = 1250;
  localparam int FAST_NS   = 250;
  localparam int RSTIN_US  = 5000;
  localparam int SEC_NS    = 1000000000;
  localparam int OUT_TOP_HZ = 20000;
  localparam int SLOW_CYC_DEF  = SLOW_US * 1000 / CLK_NS;
  localparam int MED_CYC_DEF   = MED_US * 1000 / CLK_NS;
  localparam int FAST_CYC      = (FAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int RSTIN_CYC_DEF = RSTIN_US * 1000 / CLK_NS;
  localparam int SEC_CYC_DEF   = SEC_NS / CLK_NS;
  localparam int OUT_HALF_DEF  = SEC_NS / CLK_NS / OUT_TOP_HZ / 2;

  localparam logic [15:0] CODE_RST = 16'h1000;
  localparam logic [15:0] HIST_RST = 16'hffff;
  localparam logic [13:0] PEND_MAX = 14'h270f;
  localparam logic [15:0] AN_BASE  = 16'h0fa0;
  localparam logic [63:0] AN_SPAN  = 64'h3e80;

  localparam logic [3:0] KEY_CLEAR = 4'ha;
  localparam logic [3:0] KEY_ENTER = 4'hb;
  localparam logic [3:0] KEY_START = 4'hc;
  localparam logic [3:0] KEY_STOP  = 4'hd;
  localparam logic [3:0] KEY_DMAX  = 4'h9;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_PRESET  = 8'h04;
  localparam logic [7:0] OFF_PREWARN = 8'h08;
  localparam logic [7:0] OFF_KCOUNT  = 8'h0c;
  localparam logic [7:0] OFF_KRATE   = 8'h10;
  localparam logic [7:0] OFF_WINDOW  = 8'h14;
  localparam logic [7:0] OFF_SET_LOW = 8'h18;
  localparam logic [7:0] OFF_SET_HI  = 8'h1c;
  localparam logic [7:0] OFF_CODE    = 8'h20;
  localparam logic [7:0] OFF_STATUS  = 8'h24;
  localparam logic [7:0] OFF_COUNT   = 8'h28;
  localparam logic [7:0] OFF_GRAND   = 8'h2c;
  localparam logic [7:0] OFF_RATE    = 8'h30;
  localparam logic [7:0] OFF_ANALOG  = 8'h34;

  typedef enum logic {ST_STOP = 1'b0, ST_RUN = 1'b1} run_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] code;
  } key_t;

  typedef struct packed {
    logic        mode_dn;
    logic [1:0]  spd;
    logic [31:0] preset;
    logic [31:0] prewarn;
    logic [15:0] kc;
    logic [15:0] kr;
    logic [7:0]  win;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [15:0] code;
    logic        locked;
    logic [15:0] hist;
    run_t        run;
    logic        gview;
    logic [31:0] count;
    logic [31:0] grand;
    logic [15:0] cpre;
    logic [15:0] rpre;
    logic        flt;
    logic        flt_d;
    logic [19:0] fcnt;
    logic [17:0] rcnt;
    logic [25:0] sec;
    logic [7:0]  secs;
    logic [31:0] acc;
    logic [31:0] rate;
    logic [13:0] pend;
    logic        lost;
    logic        pout;
    logic [21:0] pcnt;
    logic [15:0] analog;
    logic        a_wr;
    logic [7:0]  a_addr;
    logic [31:0] rdata;
  } state_t;

endpackage : batch_pkg

/* verif/field_source.sv */
// Model of the field pulse sensor and reset contact feeding the controller
`timescale 1ns/1ps
`default_nettype none
module field_source
(
  // Clock and wiring
  input  wire logic hclk,
  input  wire logic sink,
  // Field pins
  output logic      pulse_in,
  output var logic  reset_in
);
  logic active = 1'b0;

  // A sinking sensor pulls the line low while active, a sourcing one drives it high
  assign pulse_in = active ^ sink;

  initial reset_in = 1'b0;

  task automatic pulse(input int hi, input int lo);
    active <= 1'b1;
    repeat (hi) @(posedge hclk);
    active <= 1'b0;
    repeat (lo) @(posedge hclk);
  endtask : pulse

  task automatic hold_reset(input int n);
    reset_in <= 1'b1;
    repeat (n) @(posedge hclk);
    reset_in <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask : hold_reset
endmodule : field_source
`default_nettype wire

/* verif/tb.sv */
// Self-checking testbench of the batch counter controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import batch_pkg::*;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic [2:0]  hsize   = 3'h2;
  logic        fa      = 1'b0;
  logic        fb      = 1'b0;
  logic        pa      = 1'b0;
  logic        pb      = 1'b0;
  logic        sink    = 1'b0;
  key_t        keys    = '0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        pulse_in;
  logic        reset_in;
  logic        prewarn_relay;
  logic        preset_relay;
  logic        started;
  logic        locked;
  logic        pulse_out;
  logic        data_lost;
  logic [15:0] analog_ua;
  int          fail_count = 0;
  int          n_compared = 0;
  int          n_out      = 0;

  always #12.5 hclk = ~hclk;

  always @(posedge pulse_out) n_out++;

  batch_counter_controller #(
    .SLOW_CYC  (20),
    .MED_CYC   (12),
    .RSTIN_CYC (16),
    .SEC_CYC   (100),
    .OUT_HALF  (2)
  ) i_dut (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hreadyout),
    .hreadyout            (hreadyout),
    .hrdata               (hrdata),
    .hresp                (hresp),
    .pulse_in             (pulse_in),
    .reset_in             (reset_in),
    .filter_select_bit_a  (fa),
    .filter_select_bit_b  (fb),
    .input_polarity_bit_a (pa),
    .input_polarity_bit_b (pb),
    .keys                 (keys),
    .prewarn_relay        (prewarn_relay),
    .preset_relay         (preset_relay),
    .started              (started),
    .locked               (locked),
    .pulse_out            (pulse_out),
    .data_lost            (data_lost),
    .analog_ua            (analog_ua)
  );

  field_source i_src (
    .hclk     (hclk),
    .sink     (sink),
    .pulse_in (pulse_in),
    .reset_in (reset_in)
  );

  task automatic final_report;
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      fail_count++;
    end
  endtask : chk

  // Address phase held until hready, then data phase held until hready
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    hsize  <= 3'h2;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    hsel   <= 1'b1;
    hsize  <= 3'h2;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : rd

  task automatic ereg(input logic [7:0] a, input string what, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(what, v, exp);
  endtask : ereg

  // One key press: valid for one cycle, then an idle edge
  task automatic key(input logic [3:0] c);
    keys <= '{valid: 1'b1, code: c};
    @(posedge hclk);
    keys <= '{valid: 1'b0, code: c};
    @(posedge hclk);
  endtask : key

  task automatic code_keys;
    key(4'h1);
    key(4'h0);
    key(4'h0);
    key(4'h0);
  endtask : code_keys

  task automatic pulses(input int n);
    repeat (n) i_src.pulse(20, 20);
  endtask : pulses

  initial
  begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    final_report();
  end

  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("analog", {16'h0, analog_ua}, 32'h0fa0);
    ereg(OFF_CODE, "code", 32'h1000);
    ereg(OFF_STATUS, "status", 32'hc);
    wr(OFF_CTRL, 32'h6);
    wr(OFF_PRESET, 32'h5);
    wr(OFF_PREWARN, 32'h2);
    key(4'h3);
    key(4'h4);
    key(4'h7);
    code_keys();
    chk("locked", {31'h0, locked}, 32'h1);
    ereg(OFF_CODE, "code locked", 32'h0);
    wr(OFF_PREWARN, 32'h3);
    wr(OFF_PRESET, 32'h6);
    ereg(OFF_PREWARN, "prewarn", 32'h2);
    ereg(OFF_PRESET, "preset", 32'h6);
    code_keys();
    chk("unlocked", {31'h0, locked}, 32'h0);
    wr(OFF_PRESET, 32'h5);
    pulses(2);
    ereg(OFF_COUNT, "count idle", 32'h2);
    key(KEY_CLEAR);
    ereg(OFF_COUNT, "count clear", 32'h0);
    key(KEY_START);
    chk("start", {29'h0, started, prewarn_relay, preset_relay}, 32'h7);
    pulses(1);
    key(4'h5);
    key(KEY_CLEAR);
    ereg(OFF_COUNT, "count keys", 32'h1);
    pulses(2);
    chk("relays", {30'h0, prewarn_relay, preset_relay}, 32'h1);
    key(KEY_STOP);
    chk("stop", {29'h0, started, prewarn_relay, preset_relay}, 32'h0);
    pulses(1);
    ereg(OFF_COUNT, "count stopped", 32'h4);
    key(KEY_START);
    chk("resume", {29'h0, started, prewarn_relay, preset_relay}, 32'h5);
    ereg(OFF_COUNT, "count resume", 32'h4);
    pulses(1);
    chk("preset", {29'h0, started, prewarn_relay, preset_relay}, 32'h0);
    ereg(OFF_STATUS, "status reached", 32'hc);
    key(KEY_START);
    chk("start refused", {31'h0, started}, 32'h0);
    code_keys();
    i_src.hold_reset(8);
    ereg(OFF_COUNT, "count short reset", 32'h5);
    i_src.hold_reset(30);
    ereg(OFF_COUNT, "count reset input", 32'h0);
    key(KEY_START);
    chk("start after reset", {31'h0, started}, 32'h1);
    key(KEY_STOP);
    code_keys();
    ereg(OFF_GRAND, "grand", 32'h7);
    key(KEY_ENTER);
    ereg(OFF_STATUS, "status view", 32'h10);
    key(KEY_CLEAR);
    ereg(OFF_GRAND, "grand clear", 32'h0);
    key(KEY_ENTER);
    wr(OFF_KCOUNT, 32'h2);
    pulses(4);
    ereg(OFF_COUNT, "count scaled", 32'h2);
    wr(OFF_KCOUNT, 32'h1);
    i_src.pulse(5, 20);
    ereg(OFF_COUNT, "count fast glitch", 32'h2);
    i_src.pulse(12, 20);
    ereg(OFF_COUNT, "count fast", 32'h3);
    fa <= 1'b1;
    fb <= 1'b1;
    @(posedge hclk);
    i_src.pulse(15, 30);
    ereg(OFF_COUNT, "count slow glitch", 32'h3);
    i_src.pulse(30, 30);
    ereg(OFF_COUNT, "count slow", 32'h4);
    fb <= 1'b0;
    @(posedge hclk);
    i_src.pulse(8, 20);
    ereg(OFF_COUNT, "count medium glitch", 32'h4);
    i_src.pulse(16, 20);
    ereg(OFF_COUNT, "count medium", 32'h5);
    fa   <= 1'b0;
    pb   <= 1'b1;
    sink <= 1'b1;
    @(posedge hclk);
    i_src.pulse(12, 20);
    ereg(OFF_COUNT, "count sinking", 32'h6);
    wr(OFF_CTRL, 32'h7);
    key(KEY_CLEAR);
    ereg(OFF_COUNT, "count down clear", 32'h5);
    i_src.pulse(12, 20);
    ereg(OFF_COUNT, "count down", 32'h4);
    // Both polarity bits set: sourcing input again
    pa   <= 1'b1;
    sink <= 1'b0;
    @(posedge hclk);
    i_src.pulse(12, 20);
    ereg(OFF_COUNT, "count sourcing", 32'h3);
    // A steady 50-cycle pulse period gives exactly two rate counts per second
    repeat (6) i_src.pulse(25, 25);
    ereg(OFF_RATE, "rate", 32'h2);
    wr(OFF_SET_LOW, 32'hfffffffc);
    wr(OFF_SET_HI, 32'h4);
    ereg(8'h3c, "unmapped", 32'h0);
    hsel <= 1'b0;
    repeat (250) @(posedge hclk);
    ereg(OFF_RATE, "rate quiet", 32'h0);
    chk("analog mid", {16'h0, analog_ua}, 32'h2ee0);
    chk("output pulses", n_out, 32'd21);
    chk("data lost", {31'h0, data_lost}, 32'h0);
    final_report();
  end
endmodule : tb
`default_nettype wire
